// >>> logic/tcu_timers.sv
/*
 * Timers 0, 1 and 2 with an AXI4-Lite register slave.
 * Assumes one 10 MHz clock; pins are asynchronous and synchronised here.
 */
// Overview of operation
// - Timer 1 mode 2: low reloads from high
// - Timer 0 mode 2 works like timer 1
// - Timer 1 mode 3 freezes its count
// - Timer 0 mode 3: low byte own counter
// - Split high byte counts cycles, sets t1 flag
// - Timer 1 still runs, feeds baud pulses
// - Timer 2 function select: timer or counter
// - Timer 2 capture mode overflow sets flag
// - Trigger fall captures count, sets external flag
// - External flag requests like overflow flag
// - Timer 2 rollover reloads from capture bytes
// - Trigger fall forces reload in reload mode
// - Any clock select gives baud mode
// - Mode decode; run clear stops timer 2
// - No overflow flag in baud mode
// - Timer counts once per six clocks
// - Counter counts sampled high-then-low edges
// - Gate and run enable timers 0/1
`timescale 1ns/1ns
`include "tcu_cfg.svh"

module tcu_timers (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        t0_count_pin,
	input  wire logic        t1_count_pin,
	input  wire logic        ext_irq0_pin,
	input  wire logic        ext_irq1_pin,
	input  wire logic        t2_count_pin,
	input  wire logic        t2_trigger_input,
	output logic             t0_overflow_flag,
	output logic             t1_overflow_flag,
	output logic             t2_overflow_flag,
	output logic             t2_external_flag,
	output logic             t1_overflow_pulse,
	output logic             t2_overflow_pulse,
	output logic             rx_baud_source_select,
	output logic             tx_baud_source_select
);

	// ------------------------------------------------------------
	// Machine cycle enable and pin sampling
	// ------------------------------------------------------------
	logic [2:0] mc_cnt;
	logic       mc_en;
	logic [5:0] pin_vec;
	logic [5:0] lvl;
	logic [5:0] fall;

	// Divide by six for the machine cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mc_cnt <= 3'h0;
		end else if (mc_cnt == `TCU_MC_LAST) begin
			mc_cnt <= 3'h0;
		end else begin
			mc_cnt <= mc_cnt + 3'h1;
		end
	end
	assign mc_en = (mc_cnt == `TCU_MC_LAST);

	assign pin_vec = {t2_trigger_input, t2_count_pin, ext_irq1_pin,
		ext_irq0_pin, t1_count_pin, t0_count_pin};

	// One sampler per pin, edges found once per machine cycle
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_pin
			tcu_pin_sampler u_smp (
				.core_clk  (core_clk),
				.rst       (rst),
				.pin       (pin_vec[gi]),
				.sample_en (mc_en),
				.level     (lvl[gi]),
				.fall      (fall[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0]  tmode;
	logic        t0_run;
	logic        t1_run;
	logic [7:0]  t0_lo, t0_hi, t1_lo, t1_hi;
	logic [7:0]  t2ctl;
	logic [15:0] t2_cnt, t2_cap;

	tcu_pkg::tcu_mode_e t0_mode, t1_mode;
	assign t0_mode = tcu_pkg::tcu_mode_e'(tmode[`TCU_M_T0_MODE]);
	assign t1_mode = tcu_pkg::tcu_mode_e'(tmode[`TCU_M_T1_MODE]);

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic        aw_got, w_got, wr_fire;
	logic [7:0]  aw_addr;
	logic [31:0] w_data, w_mask, wr_old, wval;
	logic [3:0]  w_strb;
	logic        wr_ok;
	logic [32:0] rd_word;

	// Read mux: bit 32 flags a mapped address
	function automatic logic [32:0] tcu_read(input logic [7:0] a);
		unique case (a)
			`TCU_OFF_MODE:  tcu_read = {1'b1, 24'h0, tmode};
			`TCU_OFF_CTRL:  tcu_read = {1'b1, 28'h0, t1_overflow_flag,
				t0_overflow_flag, t1_run, t0_run};
			`TCU_OFF_T0:    tcu_read = {1'b1, 16'h0, t0_hi, t0_lo};
			`TCU_OFF_T1:    tcu_read = {1'b1, 16'h0, t1_hi, t1_lo};
			`TCU_OFF_T2CTL: tcu_read = {1'b1, 24'h0, t2ctl};
			`TCU_OFF_T2:    tcu_read = {1'b1, 16'h0, t2_cnt};
			`TCU_OFF_T2CAP: tcu_read = {1'b1, 16'h0, t2_cap};
			default:        tcu_read = {1'b0, 32'h0};
		endcase
	endfunction

	assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_fire       = aw_got & w_got & ~s_axi_bvalid;

	// Address and data are held until both have arrived
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got  <= 1'b1;
				aw_addr <= s_axi_awaddr[7:0];
			end else if (wr_fire) begin
				aw_got <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got  <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_got <= 1'b0;
			end
		end
	end

	// Byte lanes merged into the present register value
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			w_mask[i*8 +: 8] = {8{w_strb[i]}};
		end
		{wr_ok, wr_old} = tcu_read(aw_addr);
		wval = (wr_old & ~w_mask) | (w_data & w_mask);
	end
	assign rd_word = tcu_read(s_axi_araddr[7:0]);

	// Write response and read data
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TCU_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= `TCU_RESP_OKAY;
			s_axi_rdata  <= 32'h0;
		end else begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `TCU_RESP_OKAY : `TCU_RESP_SLV;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word[31:0];
				s_axi_rresp  <= rd_word[32] ? `TCU_RESP_OKAY : `TCU_RESP_SLV;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	logic wr_mode, wr_ctrl, wr_t0, wr_t1, wr_t2c, wr_t2, wr_cap;
	assign wr_mode = wr_fire & (aw_addr == `TCU_OFF_MODE);
	assign wr_ctrl = wr_fire & (aw_addr == `TCU_OFF_CTRL);
	assign wr_t0   = wr_fire & (aw_addr == `TCU_OFF_T0);
	assign wr_t1   = wr_fire & (aw_addr == `TCU_OFF_T1);
	assign wr_t2c  = wr_fire & (aw_addr == `TCU_OFF_T2CTL);
	assign wr_t2   = wr_fire & (aw_addr == `TCU_OFF_T2);
	assign wr_cap  = wr_fire & (aw_addr == `TCU_OFF_T2CAP);

	// ------------------------------------------------------------
	// Timers 0 and 1
	// ------------------------------------------------------------
	// One count step: {overflow, high, low}
	function automatic logic [16:0] tcu_step(
		input tcu_pkg::tcu_mode_e m,
		input logic [7:0] hi,
		input logic [7:0] lo);
		logic [13:0] v13;
		v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		unique case (m)
			tcu_pkg::TCU_M13:    tcu_step = {v13[13], v13[12:5], lo[7:5],
				v13[4:0]};
			tcu_pkg::TCU_M16:    tcu_step = {1'b0, hi, lo} + 17'h00001;
			tcu_pkg::TCU_RELOAD: tcu_step = (lo == 8'hFF) ?
				{1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
			tcu_pkg::TCU_SPLIT:  tcu_step = (lo == 8'hFF) ?
				{1'b1, hi, 8'h00} : {1'b0, hi, lo + 8'h01};
		endcase
	endfunction

	logic        t0_en, t1_en, t0_tick, t0h_tick, t1_tick, t0_split;
	logic [16:0] t0_step, t1_step;
	logic        t0_ovf, t0h_ovf, t1_ovf;

	assign t0_split = (t0_mode == tcu_pkg::TCU_SPLIT);
	assign t0_en    = t0_run & (~tmode[`TCU_M_T0_GATE] | lvl[2]);
	assign t1_en    = t1_run & (~tmode[`TCU_M_T1_GATE] | lvl[3]);
	assign t0_tick  = t0_en & (tmode[`TCU_M_T0_CT] ? fall[0] : mc_en);
	assign t0h_tick = t0_split & t1_run & mc_en;
	assign t1_tick  = (t1_mode != tcu_pkg::TCU_SPLIT) & t1_en &
		(tmode[`TCU_M_T1_CT] ? fall[1] : mc_en);
	assign t0_step  = tcu_step(t0_mode, t0_hi, t0_lo);
	assign t1_step  = tcu_step(t1_mode, t1_hi, t1_lo);
	assign t0_ovf   = t0_tick & t0_step[16];
	assign t0h_ovf  = t0h_tick & (t0_hi == 8'hFF);
	assign t1_ovf   = t1_tick & t1_step[16];

	// Mode register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tmode <= `TCU_RST_BYTE;
		end else if (wr_mode) begin
			tmode <= wval[7:0];
		end
	end

	// Timer 0 count; in split mode the high byte counts on its own
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{t0_hi, t0_lo} <= `TCU_RST_WORD;
		end else if (wr_t0) begin
			{t0_hi, t0_lo} <= wval[15:0];
		end else begin
			if (t0_tick) begin
				t0_lo <= t0_step[7:0];
			end
			if (t0_tick & ~t0_split) begin
				t0_hi <= t0_step[15:8];
			end else if (t0h_tick) begin
				t0_hi <= t0_hi + 8'h01;
			end
		end
	end

	// Timer 1 count, reload leaves the high byte alone
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{t1_hi, t1_lo} <= `TCU_RST_WORD;
		end else if (wr_t1) begin
			{t1_hi, t1_lo} <= wval[15:0];
		end else if (t1_tick) begin
			{t1_hi, t1_lo} <= t1_step[15:0];
		end
	end

	// Run bits and overflow flags; a hardware set beats a clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			t0_run           <= 1'b0;
			t1_run           <= 1'b0;
			t0_overflow_flag <= 1'b0;
			t1_overflow_flag <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				t0_run <= wval[`TCU_C_T0_RUN];
				t1_run <= wval[`TCU_C_T1_RUN];
			end
			t0_overflow_flag <= t0_ovf | (wr_ctrl ?
				wval[`TCU_C_T0_FLAG] : t0_overflow_flag);
			t1_overflow_flag <= (t1_ovf & ~t0_split) | t0h_ovf |
				(wr_ctrl ? wval[`TCU_C_T1_FLAG] : t1_overflow_flag);
		end
	end

	// ------------------------------------------------------------
	// Timer 2
	// ------------------------------------------------------------
	logic t2_baud, t2_capm, t2_tick, t2_trig, t2_ovf;

	assign t2_baud = t2ctl[`TCU_T2_RCLK] | t2ctl[`TCU_T2_TX_BAUD_SOURCE_SELECT];
	assign t2_capm = ~t2_baud & t2ctl[`TCU_T2_CAPSEL];
	assign t2_tick = t2ctl[`TCU_T2_RUN] &
		(t2ctl[`TCU_T2_CT] ? fall[4] : mc_en);
	assign t2_trig = t2ctl[`TCU_T2_EXEN] & fall[5];
	assign t2_ovf  = t2_tick & (t2_cnt == 16'hFFFF);

	// Timer 2 count: trigger reload, rollover reload or wrap
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			t2_cnt <= `TCU_RST_WORD;
		end else if (wr_t2) begin
			t2_cnt <= wval[15:0];
		end else if (t2_trig & ~t2_baud & ~t2_capm) begin
			t2_cnt <= t2_cap;
		end else if (t2_ovf) begin
			t2_cnt <= t2_capm ? 16'h0000 : t2_cap;
		end else if (t2_tick) begin
			t2_cnt <= t2_cnt + 16'h0001;
		end
	end

	// Capture/reload bytes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			t2_cap <= `TCU_RST_WORD;
		end else if (t2_trig & t2_capm) begin
			t2_cap <= t2_cnt;
		end else if (wr_cap) begin
			t2_cap <= wval[15:0];
		end
	end

	// Control byte; flags set by hardware win over a clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			t2ctl <= `TCU_RST_BYTE;
		end else begin
			if (wr_t2c) begin
				t2ctl <= wval[7:0];
			end
			if (t2_ovf & ~t2_baud) begin
				t2ctl[`TCU_T2_TF] <= 1'b1;
			end
			if (t2_trig) begin
				t2ctl[`TCU_T2_EXF] <= 1'b1;
			end
		end
	end

	// Flag outputs and baud pulses
	assign t2_overflow_flag      = t2ctl[`TCU_T2_TF];
	assign t2_external_flag      = t2ctl[`TCU_T2_EXF];
	assign rx_baud_source_select = t2ctl[`TCU_T2_RCLK];
	assign tx_baud_source_select = t2ctl[`TCU_T2_TX_BAUD_SOURCE_SELECT];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			t1_overflow_pulse <= 1'b0;
			t2_overflow_pulse <= 1'b0;
		end else begin
			t1_overflow_pulse <= t1_ovf;
			t2_overflow_pulse <= t2_ovf;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_mc_gap;
		!mc_en [*5] ##1 mc_en;
	endsequence
	property p_mc_rate;
		mc_en |=> s_mc_gap;
	endproperty
	a_mc_rate: assert property (p_mc_rate)
		else $error("machine cycle not six clocks");

	// Split timer 0 owns the timer 1 flag, so the flag is not owed then
	property p_t1_reload;
		t1_ovf && t1_mode == tcu_pkg::TCU_RELOAD && !wr_t1 && !wr_ctrl
		|=> t1_lo == $past(t1_hi) && t1_hi == $past(t1_hi) &&
		(t1_overflow_flag || $past(t0_split));
	endproperty
	a_t1_reload: assert property (p_t1_reload)
		else $error("timer 1 reload wrong");

	property p_t0_reload;
		t0_ovf && t0_mode == tcu_pkg::TCU_RELOAD && !wr_t0 && !wr_ctrl
		|=> t0_lo == $past(t0_hi) && t0_overflow_flag;
	endproperty
	a_t0_reload: assert property (p_t0_reload)
		else $error("timer 0 reload wrong");

	property p_t1_hold;
		t1_mode == tcu_pkg::TCU_SPLIT && !wr_t1 |=> $stable({t1_hi, t1_lo});
	endproperty
	a_t1_hold: assert property (p_t1_hold)
		else $error("timer 1 moved in mode 3");

	property p_split_high;
		t0_split && t1_run && mc_en && t0_hi == 8'hFF && !wr_t0 && !wr_ctrl
		|=> t0_hi == 8'h00 && t1_overflow_flag;
	endproperty
	a_split_high: assert property (p_split_high)
		else $error("split high byte overflow lost");

	property p_gate;
		!t0_run && !t0_split && !wr_t0 |=> $stable({t0_hi, t0_lo});
	endproperty
	a_gate: assert property (p_gate)
		else $error("timer 0 counted while stopped");

	property p_capture;
		t2_trig && t2_capm |=> t2_cap == $past(t2_cnt) && t2_external_flag;
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture failed");

	property p_t2_reload;
		t2_ovf && !t2_capm && !wr_t2 && !wr_cap |=> t2_cnt == $past(t2_cap);
	endproperty
	a_t2_reload: assert property (p_t2_reload)
		else $error("timer 2 reload failed");

	property p_baud_noflag;
		t2_baud && !wr_t2c |=> !$rose(t2_overflow_flag);
	endproperty
	a_baud_noflag: assert property (p_baud_noflag)
		else $error("overflow flag set in baud mode");

	property p_t2_stop;
		!t2ctl[`TCU_T2_RUN] && !t2_trig && !wr_t2 |=> $stable(t2_cnt);
	endproperty
	a_t2_stop: assert property (p_t2_stop)
		else $error("timer 2 counted while stopped");

endmodule // tcu_timers

// >>> shared/tcu_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * timer/counter unit. Assumes byte addresses on a 32-bit AXI4-Lite bus.
 */
`ifndef TCU_CFG_SVH
`define TCU_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TCU_OFF_MODE   8'h00
`define TCU_OFF_CTRL   8'h04
`define TCU_OFF_T0     8'h08
`define TCU_OFF_T1     8'h0C
`define TCU_OFF_T2CTL  8'h10
`define TCU_OFF_T2     8'h14
`define TCU_OFF_T2CAP  8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCU_M_T0_MODE  1:0
`define TCU_M_T0_CT    2
`define TCU_M_T0_GATE  3
`define TCU_M_T1_MODE  5:4
`define TCU_M_T1_CT    6
`define TCU_M_T1_GATE  7
`define TCU_C_T0_RUN   0
`define TCU_C_T1_RUN   1
`define TCU_C_T0_FLAG  2
`define TCU_C_T1_FLAG  3
`define TCU_T2_CAPSEL  0
`define TCU_T2_CT      1
`define TCU_T2_RUN     2
`define TCU_T2_EXEN    3
`define TCU_T2_TX_BAUD_SOURCE_SELECT    4
`define TCU_T2_RCLK    5
`define TCU_T2_EXF     6
`define TCU_T2_TF      7

// ----------------------------------------------------------------
// Reset values, bus answers and timing
// ----------------------------------------------------------------
`define TCU_RST_BYTE   8'h00
`define TCU_RST_WORD   16'h0000
`define TCU_RESP_OKAY  2'h0
`define TCU_RESP_SLV   2'h2
`define TCU_MC_CLOCKS  3'h6
`define TCU_MC_LAST    (`TCU_MC_CLOCKS - 3'h1)

`endif

// >>> shared/tcu_pkg.sv
/*
 * Types of the timer/counter unit.
 * Assumes tcu_cfg.svh supplies every number but the mode codes.
 */
package tcu_pkg;

	// Timer 0/1 operating modes
	typedef enum logic [1:0] {
		TCU_M13    = 2'h0,
		TCU_M16    = 2'h1,
		TCU_RELOAD = 2'h2,
		TCU_SPLIT  = 2'h3
	} tcu_mode_e;

endpackage

// >>> logic/tcu_pin_sampler.sv
/*
 * Pin synchroniser and once-per-machine-cycle falling edge finder.
 * Assumes sample_en is a one-cycle pulse on core_clk.
 */
`timescale 1ns/1ns

module tcu_pin_sampler (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic pin,
	input  wire logic sample_en,
	output logic      level,
	output logic      fall
);

	logic sync1;
	logic prev;

	// Two-flop synchroniser, level is the second flop
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1 <= 1'b0;
			level <= 1'b0;
		end else begin
			sync1 <= pin;
			level <= sync1;
		end
	end

	// Sample held from the previous machine cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev <= 1'b0;
		end else if (sample_en) begin
			prev <= level;
		end
	end

	// High in one sample, low in the next
	assign fall = sample_en & prev & ~level;

endmodule // tcu_pin_sampler

// >>> sim/tcu_pin_model.sv
/*
 * Pin model: drives the count and trigger pins of the timer unit.
 * Assumes a 100 ns core clock; pins idle high like pulled-up lines.
 */
`timescale 1ns/1ns

module tcu_pin_model (
	input  wire logic       core_clk,
	output logic      [3:0] pins
);
	// ------------------------------------------------------------
	// Pin driver
	// ------------------------------------------------------------
	// Bit 0/1 timer 0/1 counts, bit 2 timer 2 count, bit 3 trigger
	initial pins = 4'hF;

	// One falling edge, each level held 12 clocks
	task automatic fall(input int n);
		@(posedge core_clk);
		pins[n] <= 1'h0;
		repeat (12) @(posedge core_clk);
		pins[n] <= 1'h1;
		repeat (12) @(posedge core_clk);
	endtask
endmodule // tcu_pin_model

// >>> sim/test_timer_counters_0_1_2.sv
/*
 * Self-checking bench of the timer unit through its AXI4-Lite port.
 * Assumes tcu_timers, tcu_pin_model and tcu_cfg.svh are compiled.
 */
`timescale 1ns/1ns
`include "tcu_cfg.svh"

module test_timer_counters_0_1_2;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic        core_clk, rst;
	logic [31:0] awaddr, wdata, araddr, rdata, rd, c;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [3:0]  wstrb, pins, flg;
	logic [1:0]  bresp, rresp, rs;
	logic        irq0, irq1, t1_pls, t2_pls, rx_sel, tx_sel;
	logic [5:0]  ev;
	int          err_total, compares;

	// Watched events: t0, t1, t2, ext flags, t1 and t2 pulses
	assign ev = {t2_pls, t1_pls, flg};

	tcu_timers DUT (
		.core_clk(core_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .t0_count_pin(pins[0]),
		.t1_count_pin(pins[1]), .ext_irq0_pin(irq0),
		.ext_irq1_pin(irq1), .t2_count_pin(pins[2]),
		.t2_trigger_input(pins[3]), .t0_overflow_flag(flg[0]),
		.t1_overflow_flag(flg[1]), .t2_overflow_flag(flg[2]),
		.t2_external_flag(flg[3]), .t1_overflow_pulse(t1_pls),
		.t2_overflow_pulse(t2_pls), .rx_baud_source_select(rx_sel),
		.tx_baud_source_select(tx_sel)
	);

	tcu_pin_model pm (.core_clk(core_clk), .pins(pins));

	// ------------------------------------------------------------
	// Bus and checking tasks
	// ------------------------------------------------------------
	// Compare and count; report a mismatch at once
	task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
		end
	endtask

	// Write; readiness is judged at the falling edge before sampling
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
		logic ta, tw, tb;
		@(posedge core_clk);
		awaddr <= {24'h0, a};
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge core_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			rs = bresp;
			@(posedge core_clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end while (!tb);
		bready <= 1'h0;
	endtask

	// Read into rd and rs
	task automatic rdr(logic [7:0] a);
		logic ta, tr;
		@(posedge core_clk);
		araddr <= {24'h0, a};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge core_clk);
			ta = arvalid && arready;
			tr = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge core_clk);
			if (ta) arvalid <= 1'h0;
		end while (!tr);
		rready <= 1'h0;
	endtask

	// Wait up to n cycles for a watched event
	task automatic wt(int i, int n);
		repeat (n) begin
			@(negedge core_clk);
			if (ev[i]) break;
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset values, unmapped place, byte lanes
	task automatic t_regs();
		for (int a = 0; a <= 24; a += 4) begin
			rdr(a[7:0]);
			chk("reset value", rd, 32'h0);
		end
		rdr(8'h1C);
		chk("unmapped rresp", rs, `TCU_RESP_SLV);
		wr(8'h1C, 32'hFFFF);
		chk("unmapped bresp", rs, `TCU_RESP_SLV);
		wr(`TCU_OFF_T1, 32'hABCD, 4'h1);
		rdr(`TCU_OFF_T1);
		chk("low lane", rd, 32'h00CD);
	endtask

	// Gated 8-bit reload, ten machine cycles to overflow
	task automatic t_reload8(int i);
		logic [7:0] ca;
		ca = `TCU_OFF_T0 + 8'(4 * i);
		wr(`TCU_OFF_MODE, i ? 32'hA0 : 32'h0A);
		wr(ca, 32'hF6F6);
		wr(`TCU_OFF_CTRL, 32'h1 << i);
		repeat (60) @(posedge core_clk);
		rdr(ca);
		chk("gated count", rd, 32'hF6F6);
		@(posedge core_clk);
		if (i) irq1 <= 1'h1;
		else irq0 <= 1'h1;
		wt(i, 55);
		chk("early flag", ev[i], 1'h0);
		wt(i, 20);
		chk("overflow flag", ev[i], 1'h1);
		wr(`TCU_OFF_CTRL, 32'h4 << i);
		rdr(ca);
		chk("reloaded count", rd, 32'hF6F6);
		wr(`TCU_OFF_CTRL, 32'h0);
		irq0 <= 1'h0;
		irq1 <= 1'h0;
	endtask

	// Split timer 0, frozen and running timer 1
	task automatic t_split();
		wr(`TCU_OFF_MODE, 32'h33);
		wr(`TCU_OFF_T0, 32'hFEFF);
		wr(`TCU_OFF_T1, 32'h1234);
		wr(`TCU_OFF_CTRL, 32'h3);
		wt(0, 20);
		chk("low byte flag", ev[0], 1'h1);
		wt(1, 20);
		chk("high byte flag", ev[1], 1'h1);
		rdr(`TCU_OFF_T1);
		chk("t1 frozen", rd, 32'h1234);
		wr(`TCU_OFF_CTRL, 32'h0);
		wr(`TCU_OFF_T1, 32'hFFFF);
		wr(`TCU_OFF_MODE, 32'h23);
		wr(`TCU_OFF_CTRL, 32'h2);
		wt(4, 30);
		chk("t1 baud pulse", ev[4], 1'h1);
		wr(`TCU_OFF_MODE, 32'h33);
		rdr(`TCU_OFF_T1);
		c = rd;
		repeat (20) @(posedge core_clk);
		rdr(`TCU_OFF_T1);
		chk("t1 halted", rd, c);
		wr(`TCU_OFF_CTRL, 32'h0);
		wr(`TCU_OFF_MODE, 32'h0);
	endtask

	// Counter function of timers 0 and 1 in 16-bit and 13-bit modes
	task automatic t_count();
		wr(`TCU_OFF_MODE, 32'h45);
		wr(`TCU_OFF_T0, 32'hFFFE);
		wr(`TCU_OFF_T1, 32'hFF1F);
		wr(`TCU_OFF_CTRL, 32'h3);
		pm.fall(0);
		rdr(`TCU_OFF_T0);
		chk("t0 event", rd, 32'hFFFF);
		pm.fall(0);
		pm.fall(1);
		chk("t0 t1 flags", ev[1:0], 2'h3);
		rdr(`TCU_OFF_T0);
		c = rd;
		rdr(`TCU_OFF_T1);
		chk("rollover", {c[15:0], rd[15:0]}, 32'h0);
		wr(`TCU_OFF_CTRL, 32'h0);
		wr(`TCU_OFF_MODE, 32'h0);
	endtask

	// Timer 2 capture, then event counting
	task automatic t_capture();
		wr(`TCU_OFF_T2, 32'hFFF0);
		wr(`TCU_OFF_T2CTL, 32'h09);
		wr(`TCU_OFF_T2CTL, 32'h0D);
		wt(2, 150);
		chk("t2 overflow", ev[2], 1'h1);
		wr(`TCU_OFF_T2CTL, 32'h89);
		rdr(`TCU_OFF_T2);
		c = rd;
		pm.fall(3);
		chk("ext flag", ev[3], 1'h1);
		rdr(`TCU_OFF_T2CAP);
		chk("captured", rd, c);
		rdr(`TCU_OFF_T2CTL);
		chk("both flags", rd, 32'hC9);
		wr(`TCU_OFF_T2CTL, 32'h0);
		chk("flags cleared", ev[3:2], 2'h0);
		wr(`TCU_OFF_T2, 32'h0);
		wr(`TCU_OFF_T2CTL, 32'h06);
		repeat (3) pm.fall(2);
		rdr(`TCU_OFF_T2);
		chk("t2 events", rd, 32'h3);
		wr(`TCU_OFF_T2CTL, 32'h0);
	endtask

	// Timer 2 rollover reload and forced reload
	task automatic t_reload16();
		wr(`TCU_OFF_T2CAP, 32'h1200);
		wr(`TCU_OFF_T2, 32'hFFFE);
		wr(`TCU_OFF_T2CTL, 32'h04);
		wt(2, 40);
		chk("reload flag", ev[2], 1'h1);
		wr(`TCU_OFF_T2CTL, 32'h80);
		rdr(`TCU_OFF_T2);
		chk("reloaded", rd, 32'h1200);
		wr(`TCU_OFF_T2CTL, 32'h08);
		wr(`TCU_OFF_T2, 32'h5555);
		pm.fall(3);
		rdr(`TCU_OFF_T2);
		chk("forced reload", rd, 32'h1200);
		rdr(`TCU_OFF_T2CTL);
		chk("ext flag only", rd, 32'h48);
		wr(`TCU_OFF_T2CTL, 32'h0);
	endtask

	// Baud generation on either clock select, no overflow flag
	task automatic t_baud();
		wr(`TCU_OFF_T2CAP, 32'hFFFE);
		wr(`TCU_OFF_T2, 32'hFFFE);
		wr(`TCU_OFF_T2CTL, 32'h14);
		wt(5, 40);
		chk("t2 baud pulse", ev[5], 1'h1);
		chk("tx select", tx_sel, 1'h1);
		wr(`TCU_OFF_T2CTL, 32'h24);
		chk("rx select", {rx_sel, tx_sel}, 2'h2);
		wt(5, 40);
		chk("rx baud pulse", ev[5], 1'h1);
		chk("no t2 flag", ev[2], 1'h0);
		wr(`TCU_OFF_T2CTL, 32'h0);
	endtask

	// ------------------------------------------------------------
	// Clock, sequence and verdict
	// ------------------------------------------------------------
	task automatic report_and_stop();
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Clock of 100 ns
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end

	// Reset for five cycles, then every scenario
	initial begin
		rst = 1'h1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hF;
		{irq0, irq1} = 2'h0;
		err_total = 0;
		compares = 0;
		repeat (5) @(posedge core_clk);
		rst <= 1'h0;
		t_regs();
		t_reload8(0);
		t_reload8(1);
		t_split();
		t_count();
		t_capture();
		t_reload16();
		t_baud();
		report_and_stop();
	end

	// Cuts a hang short; the run needs about 1000 cycles
	initial begin
		repeat (10000) @(posedge core_clk);
		err_total++;
		report_and_stop();
	end
endmodule // test_timer_counters_0_1_2
